// file: rtl/mard_map.vh
// Constants for the mirror array data routing block
`ifndef MARD_MAP_VH
`define MARD_MAP_VH
`define MARD_PIX_W 24
`define MARD_ADDR_W 10
`define MARD_DEPTH 1024
`define MARD_SRC_VIDEO 2'h0
`define MARD_SRC_CTRL 2'h1
`define MARD_SRC_FLASH 2'h2
`define MARD_SYNC_TIMEOUT_NS 100000000
`define MARD_CLK_NS 8
`define MARD_SYNC_TIMEOUT_CYC (`MARD_SYNC_TIMEOUT_NS / `MARD_CLK_NS)
`endif

// file: rtl/mard_bus_map.v
// Output channel to array bus mapping with swap and bit reversal
`default_nettype none
module mard_bus_map
(
  // Configuration
  input wire i_dual,
  input wire i_secondary,
  input wire i_swap,
  input wire i_reverse,
  // Channel data
  input wire [23:0] i_ch_a,
  input wire [23:0] i_ch_b,
  // Array buses
  output reg [23:0] o_bus_a,
  output reg [23:0] o_bus_b,
  output reg [23:0] o_bus_c,
  output reg [23:0] o_bus_d,
  output reg o_drive_ab,
  output reg o_drive_cd
);
  wire [23:0] rev_a;
  wire [23:0] rev_b;
  wire [23:0] sel_a;
  wire [23:0] sel_b;
  genvar k;
  generate
    for (k = 0; k < 24; k = k + 1)
    begin : g_rev
      assign rev_a[k] = i_ch_a[23 - k]; // [R11]
      assign rev_b[k] = i_ch_b[23 - k]; // [R11]
    end
  endgenerate
  assign sel_a = i_reverse ? rev_a : i_ch_a;
  assign sel_b = i_reverse ? rev_b : i_ch_b;
  always @*
  begin
    o_bus_a = 24'h000000;
    o_bus_b = 24'h000000;
    o_bus_c = 24'h000000;
    o_bus_d = 24'h000000;
    o_drive_ab = 1'b0;
    o_drive_cd = 1'b0;
    if (i_dual && !i_secondary)
    begin
      // Primary of a pair feeds C and D
      o_bus_c = i_swap ? sel_b : sel_a; // [R9] [R10]
      o_bus_d = i_swap ? sel_a : sel_b; // [R9] [R10]
      o_drive_cd = 1'b1;
    end
    else
    begin
      // Single controller, or secondary of a pair, feeds A and B
      o_bus_a = i_swap ? sel_b : sel_a; // [R8] [R9] [R10]
      o_bus_b = i_swap ? sel_a : sel_b; // [R8] [R9] [R10]
      o_drive_ab = 1'b1;
    end
  end
endmodule
`default_nettype wire

// file: rtl/mard_top.v
// Mirror array data routing: frame store, pattern buffer, refresh and bus mapping
// How it works
// [R1] Only sources with periodic syncs accepted
// [R2] Source keeps syncs, sends changed frames only
// [R3] Refresh at frame rate, repeat last frame
// [R4] Patterns from video, control or flash, 24-bit
// [R5] Load patterns into memory, then stream
// [R6] External logic splits input between two controllers
// [R7] Pixels become binary PWM bit planes
// [R8] Single controller: A to A, B to B
// [R9] Dual: primary to C/D, secondary to A/B
// [R10] Optional swap of A/B or C/D
// [R11] Optional bit order reversal on outputs
// [R12] Swap and reversal fixed while streaming
`include "mard_map.vh"
`default_nettype none
module mard_top
#(
  parameter SYNC_TIMEOUT = `MARD_SYNC_TIMEOUT_CYC
)
(
  // Clock and reset
  input wire i_clk,
  input wire i_srst,
  // Video input (pins)
  input wire i_vsync,
  input wire i_den,
  input wire [23:0] i_pix,
  // Pattern load port from video, control and flash paths
  input wire [1:0] i_load_src,
  input wire i_load_valid,
  input wire [23:0] i_load_data,
  input wire i_load_last,
  // Streaming control
  input wire i_pattern_mode,
  input wire i_stream_start,
  input wire [4:0] i_bit_plane,
  // Static configuration
  input wire i_cfg_dual,
  input wire i_cfg_secondary,
  input wire i_cfg_swap,
  input wire i_cfg_reverse,
  // Array buses
  output reg [23:0] o_bus_a,
  output reg [23:0] o_bus_b,
  output reg [23:0] o_bus_c,
  output reg [23:0] o_bus_d,
  output reg o_drive_ab,
  output reg o_drive_cd,
  output reg o_frame_start,
  // Status
  output reg o_sync_lost,
  output reg o_loaded,
  output reg o_streaming
);
  localparam ST_IDLE = 2'h0;
  localparam ST_LOAD = 2'h1;
  localparam ST_SHOW = 2'h2;
  localparam [31:0] TMO = SYNC_TIMEOUT;

  reg [`MARD_PIX_W-1:0] mem [0:`MARD_DEPTH-1];
  reg vs_m;
  reg vs_s;
  reg vs_d;
  reg den_m;
  reg den_s;
  reg [23:0] pix_m;
  reg [23:0] pix_s;
  reg [1:0] state;
  reg [`MARD_ADDR_W-1:0] wr_addr;
  reg [`MARD_ADDR_W-1:0] rd_addr;
  reg [`MARD_ADDR_W-1:0] frame_len;
  reg [31:0] sync_cnt;
  reg frame_new;
  reg [23:0] rd_word;
  reg cfg_swap;
  reg cfg_reverse;
  reg cfg_dual;
  reg cfg_sec;
  reg [23:0] plane_a;
  reg [23:0] plane_b;
  wire vs_rise;
  wire wr_video;
  wire wr_load;
  wire frame_edge;
  wire [`MARD_ADDR_W-1:0] wr_ptr;
  wire [23:0] m_a;
  wire [23:0] m_b;
  wire [23:0] m_c;
  wire [23:0] m_d;
  wire m_dab;
  wire m_dcd;

  // Pins pass two flops before use
  always @(posedge i_clk)
  begin
    vs_m <= i_vsync;
    vs_s <= vs_m;
    den_m <= i_den;
    den_s <= den_m;
    pix_m <= i_pix;
    pix_s <= pix_m;
    vs_d <= vs_s;
  end

  assign vs_rise = vs_s && !vs_d;
  assign wr_video = !i_pattern_mode && den_s && !o_sync_lost; // [R1]
  assign wr_load = i_pattern_mode && (state == ST_LOAD) && i_load_valid
    && (i_load_src <= `MARD_SRC_FLASH); // [R4]
  assign frame_edge = vs_rise && !i_pattern_mode;
  // A word that arrives with the sync lands at the base of the store
  assign wr_ptr = frame_edge ? {`MARD_ADDR_W{1'b0}} : wr_addr;

  // Missing syncs mark the source unsupported; output stops refreshing outside pattern mode
  always @(posedge i_clk)
  begin
    if (i_srst || vs_rise)
      sync_cnt <= 32'h00000000;
    else if (sync_cnt != TMO)
      sync_cnt <= sync_cnt + 32'h00000001;
    if (i_srst)
      o_sync_lost <= 1'b0;
    else
      o_sync_lost <= (sync_cnt == TMO) && !vs_rise; // [R1]
  end

  always @(posedge i_clk)
  begin
    if (wr_video || wr_load)
      mem[wr_ptr] <= wr_video ? pix_s : i_load_data; // [R4] [R5]
    rd_word <= mem[rd_addr];
  end

  // Load then stream; video frames overwrite the store only when data arrives
  always @(posedge i_clk)
  begin
    if (i_srst)
    begin
      state <= ST_IDLE;
      wr_addr <= {`MARD_ADDR_W{1'b0}};
      rd_addr <= {`MARD_ADDR_W{1'b0}};
      frame_len <= {`MARD_ADDR_W{1'b1}};
      frame_new <= 1'b0;
      o_loaded <= 1'b0;
      o_streaming <= 1'b0;
      o_frame_start <= 1'b0;
      cfg_swap <= 1'b0;
      cfg_reverse <= 1'b0;
      cfg_dual <= 1'b0;
      cfg_sec <= 1'b0;
    end
    else
    begin
      o_frame_start <= 1'b0;
      // Config sampled only while not streaming so mapping never glitches
      if (!o_streaming)
      begin
        cfg_swap <= i_cfg_swap; // [R12]
        cfg_reverse <= i_cfg_reverse; // [R12]
        cfg_dual <= i_cfg_dual; // [R12]
        cfg_sec <= i_cfg_secondary; // [R12]
      end
      case (state)
        ST_IDLE:
        begin
          wr_addr <= {`MARD_ADDR_W{1'b0}};
          if (i_pattern_mode)
          begin
            state <= ST_LOAD;
            o_loaded <= 1'b0;
          end
          else if (vs_rise && !o_sync_lost)
          begin
            state <= ST_SHOW;
            o_streaming <= 1'b1;
            // The entering sync is itself the first refresh
            wr_addr <= {{(`MARD_ADDR_W-1){1'b0}}, wr_video};
            frame_new <= wr_video;
            rd_addr <= {`MARD_ADDR_W{1'b0}};
            o_frame_start <= 1'b1; // [R3]
          end
        end
        ST_LOAD:
        begin
          if (wr_load)
          begin
            wr_addr <= wr_addr + 1'b1;
            if (i_load_last)
            begin
              frame_len <= wr_addr;
              o_loaded <= 1'b1; // [R5]
            end
          end
          if (o_loaded && i_stream_start)
          begin
            state <= ST_SHOW; // [R5]
            o_streaming <= 1'b1;
            rd_addr <= {`MARD_ADDR_W{1'b0}};
          end
        end
        ST_SHOW:
        begin
          if (wr_video)
          begin
            wr_addr <= wr_addr + 1'b1;
            frame_new <= 1'b1;
          end
          if (vs_rise && !i_pattern_mode)
          begin
            // Repeat last frame unless a new one was captured
            if (frame_new)
              frame_len <= wr_addr - 1'b1; // [R3]
            // A word arriving with the sync opens the next frame, so it is kept
            frame_new <= wr_video;
            wr_addr <= {{(`MARD_ADDR_W-1){1'b0}}, wr_video};
            rd_addr <= {`MARD_ADDR_W{1'b0}}; // [R3]
            o_frame_start <= 1'b1;
          end
          else if (rd_addr == frame_len)
          begin
            rd_addr <= {`MARD_ADDR_W{1'b0}};
            if (i_pattern_mode)
              o_frame_start <= 1'b1;
          end
          else
            rd_addr <= rd_addr + 1'b1;
          if (o_sync_lost && !i_pattern_mode)
          begin
            state <= ST_IDLE; // [R1]
            o_streaming <= 1'b0;
          end
        end
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  // Binary PWM: replicate the selected bit of each pixel as a mirror plane
  always @(posedge i_clk)
  begin
    plane_a <= {24{rd_word[i_bit_plane]}} & 24'h000FFF; // [R7]
    plane_b <= {24{rd_word[i_bit_plane]}} & 24'hFFF000; // [R7]
  end

  mard_bus_map u_map
  (
    .i_dual(cfg_dual),
    .i_secondary(cfg_sec),
    .i_swap(cfg_swap),
    .i_reverse(cfg_reverse),
    .i_ch_a(plane_a),
    .i_ch_b(plane_b),
    .o_bus_a(m_a),
    .o_bus_b(m_b),
    .o_bus_c(m_c),
    .o_bus_d(m_d),
    .o_drive_ab(m_dab),
    .o_drive_cd(m_dcd)
  );

  always @(posedge i_clk)
  begin
    if (i_srst)
    begin
      o_bus_a <= 24'h000000;
      o_bus_b <= 24'h000000;
      o_bus_c <= 24'h000000;
      o_bus_d <= 24'h000000;
      o_drive_ab <= 1'b0;
      o_drive_cd <= 1'b0;
    end
    else
    begin
      o_bus_a <= o_streaming ? m_a : 24'h000000; // [R8] [R9]
      o_bus_b <= o_streaming ? m_b : 24'h000000;
      o_bus_c <= o_streaming ? m_c : 24'h000000;
      o_bus_d <= o_streaming ? m_d : 24'h000000;
      o_drive_ab <= o_streaming && m_dab;
      o_drive_cd <= o_streaming && m_dcd;
    end
  end
endmodule
`default_nettype wire

// file: verification/mard_top_sva.sv
// Port checker for the mirror array data routing top
`default_nettype none
module mard_top_sva
#(
  parameter SYNC_TIMEOUT = 50
)
(
  // Clock, reset and inputs
  input wire i_clk,
  input wire i_srst,
  input wire i_vsync,
  input wire i_pattern_mode,
  input wire [1:0] i_load_src,
  input wire i_load_valid,
  input wire i_load_last,
  input wire i_stream_start,
  input wire i_cfg_dual,
  input wire i_cfg_secondary,
  // Outputs
  input wire [23:0] o_bus_a,
  input wire [23:0] o_bus_b,
  input wire [23:0] o_bus_c,
  input wire [23:0] o_bus_d,
  input wire o_drive_ab,
  input wire o_drive_cd,
  input wire o_frame_start,
  input wire o_sync_lost,
  input wire o_loaded,
  input wire o_streaming
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);
  logic prim_q;
  // Ownership follows the captured setting, which is frozen while streaming
  always @(posedge i_clk)
    if (i_srst)
      prim_q <= 1'b0;
    else if (!o_streaming)
      prim_q <= i_cfg_dual && !i_cfg_secondary;
  wire fresh = i_pattern_mode && i_load_valid && i_load_last && !o_loaded && !o_streaming;
  int quiet;
  // Margin covers the input synchronisers
  always @(posedge i_clk)
    if (i_srst || i_vsync)
      quiet <= 0;
    else if (quiet < 1000)
      quiet <= quiet + 1;
  property p_idle_zero;
    (!o_streaming)[*4] |-> (o_bus_a | o_bus_b | o_bus_c | o_bus_d) == 24'h0;
  endproperty
  a_idle_zero: assert property (p_idle_zero) else $error("buses busy while idle");
  property p_loaded;
    fresh && $past(i_pattern_mode) && i_load_src != 2'h3 |=> o_loaded;
  endproperty
  a_loaded: assert property (p_loaded) else $error("last word not flagged");
  property p_src_refused;
    fresh && i_load_src == 2'h3 |=> !o_loaded;
  endproperty
  a_src_refused: assert property (p_src_refused) else $error("bad source taken");
  property p_start;
    o_loaded && i_stream_start && i_pattern_mode |=> o_streaming;
  endproperty
  a_start: assert property (p_start) else $error("stream did not start");
  property p_cd_owner;
    o_drive_cd |-> prim_q;
  endproperty
  a_cd_owner: assert property (p_cd_owner) else $error("pair C/D wrongly driven");
  property p_ab_owner;
    o_drive_ab |-> !prim_q;
  endproperty
  a_ab_owner: assert property (p_ab_owner) else $error("pair A/B wrongly driven");
  property p_static;
    o_streaming[*5] |-> $stable(o_drive_ab) && $stable(o_drive_cd);
  endproperty
  a_static: assert property (p_static) else $error("mapping moved mid stream");
  property p_pulse;
    o_frame_start |=> !o_frame_start;
  endproperty
  a_pulse: assert property (p_pulse) else $error("refresh pulse too long");
  property p_frame_on_vsync;
    $rose(i_vsync) && !i_pattern_mode && !o_sync_lost |-> ##[1:8] o_frame_start;
  endproperty
  a_frame_on_vsync: assert property (p_frame_on_vsync) else $error("no refresh on sync");
  property p_sync_lost;
    quiet == SYNC_TIMEOUT + 8 |-> o_sync_lost;
  endproperty
  a_sync_lost: assert property (p_sync_lost) else $error("sync loss missed");
  c_dual: cover property (o_drive_cd);
  c_regain: cover property ($fell(o_sync_lost));
  c_start: cover property (o_loaded && i_stream_start);
endmodule
bind mard_top mard_top_sva #(.SYNC_TIMEOUT(SYNC_TIMEOUT)) u_sva (.i_clk, .i_srst, .i_vsync,
  .i_pattern_mode, .i_load_src, .i_load_valid, .i_load_last, .i_stream_start, .i_cfg_dual,
  .i_cfg_secondary, .o_bus_a, .o_bus_b, .o_bus_c, .o_bus_d, .o_drive_ab, .o_drive_cd,
  .o_frame_start, .o_sync_lost, .o_loaded, .o_streaming);
`default_nettype wire

// file: verification/mard_array_model.sv
// Mirror array side model: counts refreshes, samples the driven bus pair each cycle, zero when neither pair is driven
`default_nettype none
module mard_array_model
(
  // Array side pins
  input wire logic i_clk,
  input wire logic i_frame_start,
  input wire logic i_drive_ab,
  input wire logic i_drive_cd,
  input wire logic [23:0] i_bus_a,
  input wire logic [23:0] i_bus_b,
  input wire logic [23:0] i_bus_c,
  input wire logic [23:0] i_bus_d,
  // Observations
  output var logic [47:0] o_pair,
  output var int o_frames
);
  timeunit 1ns;
  timeprecision 1ps;
  initial o_frames = 0;
  initial o_pair = 48'h0;
  always @(posedge i_clk)
  begin
    if (i_frame_start)
      o_frames <= o_frames + 1;
    if (i_drive_cd)
      o_pair <= {i_bus_c, i_bus_d};
    else if (i_drive_ab)
      o_pair <= {i_bus_a, i_bus_b};
    else
      o_pair <= 48'h0; // Undriven buses read as zero so stale data cannot pass
  end
endmodule
`default_nettype wire

// file: verification/mirror_array_data_routing_bench.sv
// Self-checking bench for the mirror array data routing top
`default_nettype none
`define CHK(a, b) \
  begin \
    total_checks++; \
    if ((a) !== (b)) \
    begin \
      n_mismatch++; \
      $display("unexpected at %0t: got %h expected %h", $time, a, b); \
    end \
  end
module mirror_array_data_routing_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, srst = 1, vsync = 0, den = 0, valid = 0, last = 0, pmode = 0, start = 0;
  logic [23:0] pix = 24'h0, data = 24'h0;
  logic [1:0] src = 2'h0;
  logic [4:0] plane = 5'h0;
  logic [3:0] cfg = 4'h0;
  logic [23:0] pat [8];
  logic [47:0] base;
  wire [47:0] pair;
  wire [23:0] ba, bb, bc, bd;
  wire dab, dcd, fs, lost, loaded, strm;
  int n_mismatch = 0, total_checks = 0, seed = 80138, cyc = 0, frames, f0;
  mard_top #(.SYNC_TIMEOUT(50)) DUT (.i_clk(clk), .i_srst(srst), .i_vsync(vsync), .i_den(den),
    .i_pix(pix), .i_load_src(src), .i_load_valid(valid), .i_load_data(data), .i_load_last(last),
    .i_pattern_mode(pmode), .i_stream_start(start), .i_bit_plane(plane), .i_cfg_dual(cfg[3]),
    .i_cfg_secondary(cfg[2]), .i_cfg_swap(cfg[1]), .i_cfg_reverse(cfg[0]), .o_bus_a(ba),
    .o_bus_b(bb), .o_bus_c(bc), .o_bus_d(bd), .o_drive_ab(dab), .o_drive_cd(dcd),
    .o_frame_start(fs), .o_sync_lost(lost), .o_loaded(loaded), .o_streaming(strm));
  mard_array_model MDL (.i_clk(clk), .i_frame_start(fs), .i_drive_ab(dab), .i_drive_cd(dcd),
    .i_bus_a(ba), .i_bus_b(bb), .i_bus_c(bc), .i_bus_d(bd), .o_pair(pair), .o_frames(frames));
  initial
    forever #4 clk = ~clk;
  function automatic logic [23:0] rev(input logic [23:0] v);
    for (int i = 0; i < 24; i++)
      rev[i] = v[23 - i];
  endfunction
  function automatic logic [47:0] exp_pair(input logic [3:0] c, input logic [47:0] b);
    logic [23:0] x, y;
    x = c[0] ? rev(b[47:24]) : b[47:24];
    y = c[0] ? rev(b[23:0]) : b[23:0];
    return c[1] ? {y, x} : {x, y};
  endfunction
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Fresh reset per run so the capture cycle is identical for every configuration
  task automatic run(input logic [3:0] c, input logic [1:0] s);
    cfg = c;
    src = s;
    pmode = 0;
    srst = 1;
    repeat (6) @(negedge clk);
    srst = 0;
    pmode = 1;
    @(negedge clk);
    for (int k = 0; k < 8; k++)
    begin
      valid = 1;
      data = pat[k];
      last = (k == 7);
      @(negedge clk);
    end
    valid = 0;
    last = 0;
    @(negedge clk);
    `CHK(loaded, s != 2'h3)
    start = 1;
    @(negedge clk);
    start = 0;
    repeat (6) @(negedge clk);
    `CHK(strm, s != 2'h3)
    $display("run cfg %h src %0d done", c, s);
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  initial
  begin
    for (int k = 0; k < 8; k++)
      pat[k] = $random(seed);
    plane = {$random(seed)} % 24;
    // The word the model holds at check time carries a set bit, so mapping checks see data
    pat[2][plane] = 1'b1;
    run(4'h0, 2'h3);
    `CHK(ba | bb | bc | bd, 24'h0)
    run(4'h0, 2'h0);
    `CHK({dab, dcd}, 2'b10)
    base = pair;
    `CHK(base, {24'h000FFF, 24'hFFF000})
    for (int i = 1; i < 16; i++)
    begin
      // Each run takes the next configuration with a source cycling through video, control and flash
      run(i[3:0], 2'(i % 3));
      `CHK(pair, exp_pair(i[3:0], base))
      `CHK({dab, dcd}, (i[3] && !i[2]) ? 2'b01 : 2'b10)
    end
    // Settings moved mid stream must not reach the buses; 8 cycles return the same word
    cfg = 4'hA;
    repeat (8) @(negedge clk);
    `CHK({dab, dcd}, 2'b10)
    `CHK(pair, exp_pair(4'hF, base))
    $display("static config test done");
    cfg = 4'h0;
    pmode = 0;
    srst = 1;
    repeat (6) @(negedge clk);
    srst = 0;
    repeat (70) @(negedge clk);
    `CHK(lost, 1'b1)
    f0 = frames;
    for (int k = 0; k < 6; k++)
    begin
      // Syncs keep running; only the first frames bring new data
      vsync = 1;
      den = (k < 3);
      pix = $random(seed);
      repeat (3) @(negedge clk);
      vsync = 0;
      den = 0;
      repeat (17) @(negedge clk);
    end
    `CHK(lost, 1'b0)
    `CHK(frames - f0, 5)
    `CHK(strm, 1'b1)
    $display("video sync test done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
